// ===== adc_trigger_result_control.sv
// Converter trigger, prescaler, done flag and result register logic
//
// Added by the designer: the plain strobed port.
module adc_trigger_result_control #(
   parameter int RES_W = 10
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [7:1] TRIG_FLAGS,
   input wire logic GLOBAL_IRQ_EN,
   input wire logic IRQ_ACK,
   input wire logic signed [10:0] CONV_DIFF,
   output logic IRQ,
   output logic CONV_CLK_TICK,
   output logic CONV_BUSY,
   output logic COMPARATOR_MUX_ENABLE
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (RES_W != 10) begin : g_width_check
      $error("Result width must be 10");
   end

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_IDLE,
      ST_CONV
   } conv_state_t;

   typedef struct packed {
      conv_state_t state;
      logic enable;
      logic auto_en;
      logic flag;
      logic irq_en;
      logic [2:0] div_sel;
      logic [7:0] trig_fmt;
      logic [9:0] result;
      logic lock;
      logic first;
      logic [6:0] pre_cnt;
      logic tick;
      logic [4:0] conv_cnt;
      logic [2:0] src_prev;
      logic lvl_prev;
      logic [7:0] rdata;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   // Terminal count of the prescaler for a divider code
   function automatic logic [6:0] div_last(input logic [2:0] sel);
      logic [7:0] d;
      d = 8'h01 << ((sel == 3'h0) ? 3'h1 : sel);
      return 7'(d - 8'h01);
   endfunction : div_last

   // Result byte pair for the given alignment
   function automatic logic [15:0] present(input logic [9:0] res, input logic left);
      logic [15:0] v;
      if (left) begin
         v = {res, 6'h00};
      end else begin
         v = {6'h00, res};
      end
      return v;
   endfunction : present

   // Clamp the raw input difference to the selected format
   function automatic logic [9:0] format_res(input logic signed [10:0] diff, input logic bip);
      logic [9:0] r;
      if (bip) begin
         if (diff > 11'sh1FF) begin
            r = adc_ctrl_pkg::BIP_MAX;
         end else if (diff < -11'sh200) begin
            r = adc_ctrl_pkg::BIP_MIN;
         end else begin
            r = diff[9:0];
         end
      end else if (diff <= 11'sh000 || diff > 11'sh3FF) begin
         r = adc_ctrl_pkg::UNI_FULL_SCALE;
      end else begin
         r = diff[9:0];
      end
      return r;
   endfunction : format_res

   // ---------------------------------------------------------------
   // Combinational helpers
   // ---------------------------------------------------------------
   logic [2:0] src_sel;
   logic src_level;
   logic trig_edge;
   logic start_wr;
   logic flag_wr_clr;
   logic conv_done;
   logic [15:0] shown;

   assign src_sel = st_r.trig_fmt[2:0];
   assign shown = present(st_r.result, st_r.trig_fmt[adc_ctrl_pkg::TF_LEFT]);

   // Selected trigger level, free running watches the done flag
   always_comb begin
      if (src_sel == adc_ctrl_pkg::SRC_FREE_RUN) begin
         src_level = st_r.flag;
      end else begin
         src_level = TRIG_FLAGS[src_sel];
      end
   end

   // Rising edge, including a switch from a clear to a set source
   assign trig_edge = src_level && !st_r.lvl_prev
      && !(src_sel == adc_ctrl_pkg::SRC_FREE_RUN && st_r.src_prev != adc_ctrl_pkg::SRC_FREE_RUN);

   assign start_wr = WR && ADDR == adc_ctrl_pkg::OFS_CTRL_STAT && WDATA[adc_ctrl_pkg::CS_START];
   assign flag_wr_clr = WR && ADDR == adc_ctrl_pkg::OFS_CTRL_STAT && WDATA[adc_ctrl_pkg::CS_FLAG];
   assign conv_done = st_r.state == ST_CONV && st_r.tick && st_r.conv_cnt == 5'd1;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic go;
      logic en_now;
      go = 1'b0;
      en_now = st_r.enable;
      st_nxt = st_r;
      st_nxt.tick = 1'b0;

      // Register writes
      if (WR) begin
         case (ADDR)
            adc_ctrl_pkg::OFS_CTRL_STAT: begin
               en_now = WDATA[adc_ctrl_pkg::CS_ENABLE];
               st_nxt.enable = en_now;
               st_nxt.auto_en = WDATA[adc_ctrl_pkg::CS_AUTO];
               st_nxt.irq_en = WDATA[adc_ctrl_pkg::CS_IE];
               st_nxt.div_sel = WDATA[2:0];
               if (en_now && !st_r.enable) begin
                  st_nxt.first = 1'b1;
               end
            end
            adc_ctrl_pkg::OFS_TRIG_FMT: begin
               st_nxt.trig_fmt = WDATA;
            end
            default: begin
            end
         endcase
      end

      // Done flag clears by vector entry or by writing one
      if (flag_wr_clr || IRQ_ACK) begin
         st_nxt.flag = 1'b0;
      end

      // Prescaler runs only while enabled
      if (!st_r.enable) begin
         st_nxt.pre_cnt = 7'h00;
      end else if (st_r.pre_cnt >= div_last(st_r.div_sel)) begin
         st_nxt.pre_cnt = 7'h00;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.pre_cnt = st_r.pre_cnt + 7'h01;
      end

      // Edge detector history
      st_nxt.lvl_prev = src_level;
      st_nxt.src_prev = src_sel;

      // Start sources
      if (start_wr) begin
         go = 1'b1;
      end
      if (st_r.enable && st_r.auto_en && trig_edge) begin
         go = 1'b1;
      end

      // Conversion sequencing
      case (st_r.state)
         ST_IDLE: begin
            if (go && en_now) begin
               st_nxt.state = ST_CONV;
               st_nxt.conv_cnt = (st_r.first || (en_now && !st_r.enable))
                  ? adc_ctrl_pkg::FIRST_CONV_CLKS : adc_ctrl_pkg::NORMAL_CONV_CLKS;
               st_nxt.first = 1'b0;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               st_nxt.state = ST_IDLE;
               if (!st_r.lock) begin
                  st_nxt.result = format_res(CONV_DIFF, st_r.trig_fmt[adc_ctrl_pkg::TF_BIPOLAR]);
                  st_nxt.flag = 1'b1;
               end
            end else if (st_r.tick) begin
               st_nxt.conv_cnt = st_r.conv_cnt - 5'd1;
            end
         end
         default: begin
            st_nxt.state = ST_IDLE;
         end
      endcase

      // Turning the converter off aborts the conversion
      if (!en_now) begin
         st_nxt.state = ST_IDLE;
         st_nxt.conv_cnt = 5'd0;
      end

      // Register reads, data one cycle later
      st_nxt.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            adc_ctrl_pkg::OFS_CTRL_STAT: begin
               st_nxt.rdata = {st_r.enable, st_r.state == ST_CONV, st_r.auto_en,
                  st_r.flag, st_r.irq_en, st_r.div_sel};
            end
            adc_ctrl_pkg::OFS_TRIG_FMT: begin
               st_nxt.rdata = st_r.trig_fmt;
            end
            adc_ctrl_pkg::OFS_RES_LO: begin
               st_nxt.rdata = shown[7:0];
               st_nxt.lock = 1'b1;
            end
            adc_ctrl_pkg::OFS_RES_HI: begin
               st_nxt.rdata = shown[15:8];
               st_nxt.lock = 1'b0;
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_r.state <= ST_IDLE;
         st_r.enable <= adc_ctrl_pkg::CTRL_STAT_RST[adc_ctrl_pkg::CS_ENABLE];
         st_r.auto_en <= adc_ctrl_pkg::CTRL_STAT_RST[adc_ctrl_pkg::CS_AUTO];
         st_r.flag <= adc_ctrl_pkg::CTRL_STAT_RST[adc_ctrl_pkg::CS_FLAG];
         st_r.irq_en <= adc_ctrl_pkg::CTRL_STAT_RST[adc_ctrl_pkg::CS_IE];
         st_r.div_sel <= adc_ctrl_pkg::CTRL_STAT_RST[2:0];
         st_r.trig_fmt <= adc_ctrl_pkg::TRIG_FMT_RST;
         st_r.result <= adc_ctrl_pkg::RESULT_RST;
         st_r.lock <= 1'b0;
         st_r.first <= 1'b1;
         st_r.pre_cnt <= 7'h00;
         st_r.tick <= 1'b0;
         st_r.conv_cnt <= 5'd0;
         st_r.src_prev <= adc_ctrl_pkg::SRC_FREE_RUN;
         st_r.lvl_prev <= 1'b0;
         st_r.rdata <= 8'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign RDATA = st_r.rdata;
   assign IRQ = st_r.flag && st_r.irq_en && GLOBAL_IRQ_EN;
   assign CONV_CLK_TICK = st_r.tick;
   assign CONV_BUSY = st_r.state == ST_CONV;
   assign COMPARATOR_MUX_ENABLE = st_r.trig_fmt[adc_ctrl_pkg::TF_CMP_MUX];

endmodule : adc_trigger_result_control

// ===== adc_ctrl_pkg.sv
// Constants for the converter trigger, prescaler and result control block
//
// Overview of operation
// - With auto trigger on, each rising edge of the chosen trigger while idle starts a conversion; edges during a conversion are ignored.
// - Done flag sets when a conversion ends and the result registers update.
// - Interrupt request is flag AND interrupt enable AND processor global enable.
// - Done flag clears when the processor runs the matching interrupt vector.
// - Writing one to the done flag clears it; writing zero leaves it.
// - Divider codes 000 and 001 divide by 2, then 4 up to 128.
// - Reading the low byte blocks result updates until the high byte is read.
// - Right aligned: bits 9:8 in high byte 1:0, bits 7:0 in low byte.
// - Left aligned: bits 9:2 in high byte, bits 1:0 in low byte 7:6.
// - A left align change alters the presented result at once.
// - Unipolar gives a 10-bit result, saturating when positive is not above negative.
// - Bipolar mode gives a two's complement result, nine bits plus sign.
// - Reserved bits 5 and 3 of the trigger register read back as written.
// - Trigger source select does nothing while auto trigger is off.
// - Source codes: free run, comparator, ext int 0, t0 A, t0 ovf, t1 B, t1 ovf, t1 capture.
// - Switching from a clear source to a set source counts as a rising edge.
// - Switching to free running alone never gives a trigger event.
// - Writing one to start begins a conversion; it reads one while busy.
// - First conversion after enabling takes 25 converter clocks, later ones 13.
// - Enable bit turns the converter on; clearing it aborts a running conversion.
package adc_ctrl_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_TRIG_FMT = 8'h03;
   localparam logic [7:0] OFS_RES_LO = 8'h04;
   localparam logic [7:0] OFS_RES_HI = 8'h05;
   localparam logic [7:0] OFS_CTRL_STAT = 8'h06;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CS_ENABLE = 7;
   localparam int CS_START = 6;
   localparam int CS_AUTO = 5;
   localparam int CS_FLAG = 4;
   localparam int CS_IE = 3;
   localparam int TF_BIPOLAR = 7;
   localparam int TF_CMP_MUX = 6;
   localparam int TF_LEFT = 4;

   // ---------------------------------------------------------------
   // Reset values and timing counts
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_STAT_RST = 8'h00;
   localparam logic [7:0] TRIG_FMT_RST = 8'h00;
   localparam logic [9:0] RESULT_RST = 10'h000;
   localparam logic [4:0] FIRST_CONV_CLKS = 5'd25;
   localparam logic [4:0] NORMAL_CONV_CLKS = 5'd13;
   localparam logic [2:0] SRC_FREE_RUN = 3'h0;
   localparam logic [9:0] UNI_FULL_SCALE = 10'h3FF;
   localparam logic [9:0] BIP_MAX = 10'h1FF;
   localparam logic [9:0] BIP_MIN = 10'h200;

endpackage : adc_ctrl_pkg

// ===== adc_trc_checker.sv
// Port assertions for the converter control block
module adc_trc_checker (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic GLOBAL_IRQ_EN,
   input wire logic IRQ_ACK,
   input wire logic IRQ,
   input wire logic CONV_CLK_TICK,
   input wire logic CONV_BUSY,
   input wire logic COMPARATOR_MUX_ENABLE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic csw;
   // Write to the control and status register
   assign csw = WR && ADDR == 8'h06;
   logic [11:0] busy_cnt;
   // Cycles spent busy in the running conversion, held at its top value
   always_ff @(posedge CLK_SYS) begin
      if (RST || !CONV_BUSY) begin
         busy_cnt <= 12'h000;
      end else if (busy_cnt != 12'hFFF) begin
         busy_cnt <= busy_cnt + 12'h001;
      end
   end
   AST_IRQ_GATE: assert property (IRQ |-> GLOBAL_IRQ_EN) else $error("irq without global enable");
   AST_IRQ_SRC: assert property ($rose(IRQ) && $past(GLOBAL_IRQ_EN) && !$past(WR) |-> $fell(CONV_BUSY))
      else $error("irq rose without completion");
   AST_ACK_CLR: assert property (IRQ_ACK && !CONV_BUSY |=> !IRQ) else $error("ack left irq");
   AST_W1C: assert property (csw && WDATA[4] && !CONV_BUSY |=> !IRQ) else $error("flag not cleared");
   AST_START: assert property (csw && WDATA[7:6] == 2'b11 && !CONV_BUSY |=> CONV_BUSY)
      else $error("start ignored");
   AST_ABORT: assert property (csw && !WDATA[7] |=> !CONV_BUSY) else $error("abort ignored");
   AST_TICK: assert property (CONV_CLK_TICK |=> !CONV_CLK_TICK) else $error("tick too long");
   AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00) else $error("read data without read");
   AST_MUX: assert property (WR && ADDR == 8'h03 |=> COMPARATOR_MUX_ENABLE == $past(WDATA[6]))
      else $error("mux bit not stored");
   AST_CONV_END: assert property (CONV_BUSY |-> busy_cnt <= 12'd3400)
      else $error("conversion too long");
   AST_CONV_MIN: assert property ($fell(CONV_BUSY) && !$past(csw) |-> busy_cnt >= 12'd20)
      else $error("conversion too short");
endmodule : adc_trc_checker

bind adc_trigger_result_control adc_trc_checker adc_trc_checker_i (.CLK_SYS(CLK_SYS), .RST(RST),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
   .IRQ_ACK(IRQ_ACK), .IRQ(IRQ), .CONV_CLK_TICK(CONV_CLK_TICK), .CONV_BUSY(CONV_BUSY),
   .COMPARATOR_MUX_ENABLE(COMPARATOR_MUX_ENABLE));

// ===== testbench.sv
// Self-checking testbench for the converter control block
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst = 1, wr = 0, rd = 0, gie = 0, ack = 0;
   logic [7:0] addr = 0, wdata = 0, rdata;
   logic [7:1] trig = 0;
   logic signed [10:0] diff = 0;
   logic irq, tick, busy, mux;
   int num_errors = 0, check_count = 0, n;
   // Clock generator
   always #5 clk_sys = ~clk_sys;
   adc_trigger_result_control adc_trigger_result_control_i (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TRIG_FLAGS(trig), .GLOBAL_IRQ_EN(gie),
      .IRQ_ACK(ack), .CONV_DIFF(diff), .IRQ(irq), .CONV_CLK_TICK(tick), .CONV_BUSY(busy),
      .COMPARATOR_MUX_ENABLE(mux));
   // ---------------------------------------------------------------
   // Bus and wait tasks
   // ---------------------------------------------------------------
   task automatic settle(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : settle
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_reg
   task automatic wait_done();
      n = 0;
      while (busy !== 1'b0 && n < 5000) begin
         settle(1);
         n++;
      end
      if (n >= 5000) num_errors++;
   endtask : wait_done
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   // Watchdog
   initial begin
      #400000;
      num_errors++;
      test_done();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      for (int a = 3; a < 8; a++) rd_reg(8'(a), 8'h00);
      wr_reg(8'h03, 8'h68);
      rd_reg(8'h03, 8'h68);
      `CHK(mux, 1'b1)
      wr_reg(8'h03, 8'h00);
      diff <= 11'sd677;
      gie <= 1'b1;
      wr_reg(8'h06, 8'hC8);
      wait_done();
      `CHK(n inside {[47:54]}, 1'b1)
      `CHK(irq, 1'b1)
      rd_reg(8'h06, 8'h98);
      rd_reg(8'h04, 8'hA5);
      rd_reg(8'h05, 8'h02);
      wr_reg(8'h03, 8'h10);
      rd_reg(8'h04, 8'h40);
      rd_reg(8'h05, 8'hA9);
      gie <= 1'b0;
      settle(1);
      `CHK(irq, 1'b0)
      gie <= 1'b1;
      wr_reg(8'h06, 8'h88);
      rd_reg(8'h06, 8'h98);
      wr_reg(8'h06, 8'h98);
      rd_reg(8'h06, 8'h88);
      wr_reg(8'h03, 8'h00);
      rd_reg(8'h04, 8'hA5);
      diff <= -11'sd3;
      wr_reg(8'h06, 8'hCA);
      wait_done();
      `CHK(n inside {[47:58]}, 1'b1)
      rd_reg(8'h06, 8'h8A);
      rd_reg(8'h05, 8'h02);
      wr_reg(8'h06, 8'hCA);
      wait_done();
      `CHK(irq, 1'b1)
      ack <= 1'b1;
      settle(1);
      ack <= 1'b0;
      `CHK(irq, 1'b0)
      rd_reg(8'h04, 8'hFF);
      rd_reg(8'h05, 8'h03);
      wr_reg(8'h03, 8'h80);
      for (int i = 0; i < 2; i++) begin
         diff <= i ? 11'sd600 : -11'sd5;
         wr_reg(8'h06, 8'hCA);
         wait_done();
         rd_reg(8'h04, 8'hFB | 8'(i * 4));
         rd_reg(8'h05, 8'h03 - 8'(i * 2));
      end
      for (int s = 1; s < 8; s++) begin
         trig <= 7'h00;
         wr_reg(8'h06, 8'hB0);
         wr_reg(8'h03, 8'(s));
         `CHK(busy, 1'b0)
         trig[s] <= 1'b1;
         settle(3);
         `CHK(busy, 1'b1)
         wait_done();
      end
      trig <= 7'h00;
      wr_reg(8'h06, 8'h90);
      trig <= 7'h7F;
      settle(3);
      `CHK(busy, 1'b0)
      trig <= 7'h02;
      wr_reg(8'h03, 8'h01);
      wr_reg(8'h06, 8'hB0);
      `CHK(busy, 1'b0)
      wr_reg(8'h03, 8'h02);
      settle(2);
      `CHK(busy, 1'b1)
      wait_done();
      wr_reg(8'h03, 8'h00);
      settle(3);
      `CHK(busy, 1'b0)
      wr_reg(8'h06, 8'hF0);
      wait_done();
      settle(4);
      `CHK(busy, 1'b1)
      wr_reg(8'h06, 8'h87);
      // Wait for one converter tick, then time the gap to the next one
      for (int k = 0; k < 2; k++) begin
         n = 0;
         settle(1);
         while (tick !== 1'b1 && n < 300) begin
            settle(1);
            n++;
         end
      end
      `CHK(n, 128 - 1)
      wr_reg(8'h06, 8'h00);
      `CHK(busy, 1'b0)
      test_done();
   end
endmodule : testbench
